// >>> dv/fpiv_core_model.sv
// Processor core model that acknowledges offers and fetches their vectors.
`timescale 1ns/100ps
module fpiv_core_model
   import fpiv_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // Offer and control
   input wire fpiv_core_t core_req,
   input wire logic ack_en,
   // Handshake and fetch
   output logic core_ack,
   output logic [15:0] fetched
);
   // Acknowledges at most every other cycle; the vector is taken at the edge at which
   // the block samples the acknowledge, so it belongs to the offer acknowledged.
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         core_ack <= 1'b0;
         fetched <= 16'h0000;
      end else begin
         core_ack <= ack_en && !core_ack && (core_req.irq || core_req.nmi);
         if (core_ack) begin
            fetched <= core_req.vector;
         end
      end
   end
endmodule

// >>> dv/fpiv_top_test.sv
// Self-checking testbench for the interrupt vectoring block.
`timescale 1ns/100ps
module fpiv_top_test
   import fpiv_pkg::*;
;
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic nmi_mode = 1'b0;
   logic men = 1'b1;
   logic ack_en = 1'b0;
   logic [15:0] ev = 16'h0000;
   logic [15:0] irq_mask = 16'h0000;
   fpiv_flag_wr_t flag_wr = '0;
   fpiv_core_t core_req;
   logic core_ack, nmi_p, stby;
   logic [15:0] fetched, flags, flags_b;
   int fail_count = 0;
   int n_checks = 0;
   fpiv_top DUT (.core_clk(core_clk), .sys_rst(sys_rst), .watchdog_overflow(ev[0]),
      .watchdog_nmi_mode(nmi_mode), .pin_edge_irq_0(ev[1]), .pin_edge_irq_1(ev[2]),
      .pin_edge_irq_2(ev[3]), .serial_rx_error_irq(ev[4]), .serial_rx_done_irq(ev[5]),
      .serial_tx_done_irq(ev[6]), .timer16_match_irq(ev[7]), .timer16_overflow_irq(ev[8]),
      .timer16_combined_irq(ev[9]), .timer8_match_irq(ev[10]), .watch_interval_irq(ev[11]),
      .watch_main_irq(ev[12]), .key_return_irq(ev[13]), .pin_edge_irq_3(ev[14]),
      .pin_edge_irq_4(ev[15]), .irq_mask(irq_mask), .maskable_enable(men),
      .flag_wr(flag_wr), .core_ack(core_ack), .core_req_ff(core_req),
      .request_flags_ff(flags), .nmi_pending_ff(nmi_p), .standby_release_ff(stby));
   fpiv_top #(.EXTENDED(1'b0)) DUT_BASE (.core_clk(core_clk), .sys_rst(sys_rst),
      .watchdog_overflow(ev[0]), .watchdog_nmi_mode(nmi_mode), .pin_edge_irq_0(ev[1]),
      .pin_edge_irq_1(ev[2]), .pin_edge_irq_2(ev[3]), .serial_rx_error_irq(ev[4]),
      .serial_rx_done_irq(ev[5]), .serial_tx_done_irq(ev[6]), .timer16_match_irq(ev[7]),
      .timer16_overflow_irq(ev[8]), .timer16_combined_irq(ev[9]),
      .timer8_match_irq(ev[10]), .watch_interval_irq(ev[11]), .watch_main_irq(ev[12]),
      .key_return_irq(ev[13]), .pin_edge_irq_3(ev[14]), .pin_edge_irq_4(ev[15]),
      .irq_mask(irq_mask), .maskable_enable(men), .flag_wr(flag_wr), .core_ack(1'b0),
      .core_req_ff(), .request_flags_ff(flags_b), .nmi_pending_ff(),
      .standby_release_ff());
   fpiv_core_model core (.core_clk(core_clk), .sys_rst(sys_rst), .core_req(core_req),
      .ack_en(ack_en), .core_ack(core_ack), .fetched(fetched));
   initial begin
      forever #2.5 core_clk = ~core_clk;
   end
   task automatic conclude();
      if (fail_count == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tick();
      @(posedge core_clk);
      #1;
   endtask
   task automatic pulse(input logic [15:0] v);
      ev = v;
      tick();
      ev = 16'h0000;
   endtask
   task automatic drain();
      int i;
      ack_en = 1'b1;
      for (i = 0; i < 100 && (flags !== 16'h0000 || nmi_p !== 1'b0); i++) tick();
      ack_en = 1'b0;
      if (i == 100) begin
         fail_count++;
         conclude();
      end
      tick();
      tick();
   endtask
   task automatic t_each();
      for (int i = 0; i < 16; i++) begin
         pulse(16'h0001 << i);
         chk(flags, 16'h0001 << i);
         chk(core_req, {2'b01, i[3:0], 16'h0004 + 16'(2 * i)});
         chk(stby, 1'b1);
         chk(flags_b[15:14], 2'b00);
         drain();
         chk(fetched, 16'h0004 + 16'(2 * i));
         chk(stby, 1'b0);
      end
   endtask
   task automatic t_prio();
      pulse(16'hFFFF);
      chk(core_req[19:16], 4'h0);
      irq_mask = 16'h0001;
      tick();
      chk(core_req[19:16], 4'h1);
      chk(flags, 16'hFFFF);
      irq_mask = 16'h0000;
      drain();
      chk(fetched, 16'h0022);
      chk(flags_b, BASE_SRC_MASK);
   endtask
   task automatic t_nmi();
      nmi_mode = 1'b1;
      men = 1'b0;
      pulse(16'h0003);
      chk(flags, 16'h0002);
      chk({core_req[21], core_req[15:0]}, {1'b1, VEC_NMI});
      chk({nmi_p, stby}, 2'b11);
      men = 1'b1;
      drain();
      chk(fetched, 16'h0006);
      nmi_mode = 1'b0;
   endtask
   task automatic t_swr();
      men = 1'b0;
      ev = 16'h0400;
      flag_wr = '{1'b1, 16'h0C00, 16'h0800};
      tick();
      ev = 16'h0000;
      flag_wr = '0;
      chk(flags, 16'h0C00);
      chk({core_req, stby}, 23'h000001);
      men = 1'b1;
      tick();
      chk(core_req, {2'b01, 4'hA, 16'h0018});
      flag_wr = '{1'b1, 16'h0C00, 16'h0000};
      tick();
      flag_wr = '0;
      tick();
      chk({stby, flags}, 17'h00000);
   endtask
   initial begin
      repeat (20) @(posedge core_clk);
      #1 sys_rst = 1'b0;
      chk({core_req, nmi_p, stby}, 24'h000000);
      chk(flags, FLAGS_RESET);
      t_each();
      t_prio();
      t_nmi();
      t_swr();
      conclude();
   end
endmodule

// >>> include/fpiv_pkg.sv
// Package with constants and types for the fixed priority interrupt vectoring block.
package fpiv_pkg;
   localparam int NUM_SRC = 16;
   localparam int NUM_SRC_BASE = 14;
   localparam logic [3:0] IDX_WATCHDOG = 4'h0;
   localparam logic [3:0] IDX_PIN_EDGE_3 = 4'hE;
   localparam logic [3:0] IDX_PIN_EDGE_4 = 4'hF;
   localparam logic [15:0] VEC_NMI = 16'h0004;
   localparam logic [15:0] VEC_BASE = 16'h0004;
   localparam logic [15:0] FLAGS_RESET = 16'h0000;
   localparam logic [15:0] BASE_SRC_MASK = 16'h3FFF;
   localparam logic [15:0] EXT_SRC_MASK = 16'hFFFF;

   typedef struct packed {
      logic nmi;
      logic irq;
      logic [3:0] index;
      logic [15:0] vector;
   } fpiv_core_t;

   typedef struct packed {
      logic wr_en;
      logic [15:0] wr_sel;
      logic [15:0] wr_data;
   } fpiv_flag_wr_t;
endpackage

// >>> src/fpiv_arbiter.sv
// Fixed priority encoder: lowest index with a pending request wins.
`timescale 1ns/100ps
module fpiv_arbiter
   import fpiv_pkg::*;
(
   // Requests
   input wire logic [15:0] req,
   // Result
   output logic found,
   output logic [3:0] index
);
   logic [15:0] grant;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_SRC; gi++) begin : g_grant
         if (gi == 0) begin : g_first
            assign grant[gi] = req[gi];
         end else begin : g_rest
            assign grant[gi] = req[gi] & ~|req[gi-1:0];
         end
      end
   endgenerate

   always_comb begin
      index = 4'h0;
      for (int i = 0; i < NUM_SRC; i++) begin
         if (grant[i]) begin
            index = 4'(i);
         end
      end
      found = |req;
   end
endmodule

// >>> src/fpiv_top.sv
// Interrupt flag latching, masking, fixed priority arbitration and vector output.
`timescale 1ns/100ps
//Overview of operation
// - Watchdog NMI unmaskable, always beats maskable requests.
// - Any request raises standby release.
// - Only watchdog overflow drives the NMI.
// - Watchdog mode 1 overflow: NMI, vector 0004H.
// - Interval mode overflow: maskable, priority 0.
// - Masked sources are never offered to core.
// - Simultaneous maskable requests: best priority wins.
// - Base variant priorities 0 to 13.
// - Extended variant adds priorities 14, 15.
// - Pin edges 0-2: priorities 1-3.
// - Serial error, receive, transmit: priorities 4-6.
// - Timer16 match, overflow, combined: priorities 7-9.
// - Timer8, watch interval, watch main: 10-12.
// - Key return: priority 13, vector 001EH.
// - Base 14 sources, extended 16 sources.
// - Flag sets on request, clears on ack/write.
// - Reset clears all request flags.
module fpiv_top
   import fpiv_pkg::*;
#(
   parameter bit EXTENDED = 1'b1
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // Watchdog
   input wire logic watchdog_overflow,
   input wire logic watchdog_nmi_mode,
   // Maskable event pulses
   input wire logic pin_edge_irq_0,
   input wire logic pin_edge_irq_1,
   input wire logic pin_edge_irq_2,
   input wire logic pin_edge_irq_3,
   input wire logic pin_edge_irq_4,
   input wire logic serial_rx_error_irq,
   input wire logic serial_rx_done_irq,
   input wire logic serial_tx_done_irq,
   input wire logic timer16_match_irq,
   input wire logic timer16_overflow_irq,
   input wire logic timer16_combined_irq,
   input wire logic timer8_match_irq,
   input wire logic watch_interval_irq,
   input wire logic watch_main_irq,
   input wire logic key_return_irq,
   // Mask, enable and flag write from the core
   input wire logic [15:0] irq_mask,
   input wire logic maskable_enable,
   input wire fpiv_flag_wr_t flag_wr,
   input wire logic core_ack,
   // Outputs to the core
   output fpiv_core_t core_req_ff,
   output logic [15:0] request_flags_ff,
   output logic nmi_pending_ff,
   output logic standby_release_ff
);
   localparam logic [15:0] SRC_VALID = EXTENDED ? EXT_SRC_MASK : BASE_SRC_MASK;

   logic [15:0] src_evt;
   logic [15:0] ack_clr;
   logic [15:0] nxt_flags;
   logic [15:0] eligible;
   logic nxt_nmi;
   logic win_found;
   logic [3:0] win_index;
   fpiv_core_t nxt_core_req;
   logic nxt_standby;
   logic ack_maskable;
   logic ack_nmi;

   // Source order is the priority order; index 0 is the best rank.
   always_comb begin
      src_evt = 16'h0000;
      src_evt[0] = watchdog_overflow & ~watchdog_nmi_mode;
      src_evt[1] = pin_edge_irq_0;
      src_evt[2] = pin_edge_irq_1;
      src_evt[3] = pin_edge_irq_2;
      src_evt[4] = serial_rx_error_irq;
      src_evt[5] = serial_rx_done_irq;
      src_evt[6] = serial_tx_done_irq;
      src_evt[7] = timer16_match_irq;
      src_evt[8] = timer16_overflow_irq;
      src_evt[9] = timer16_combined_irq;
      src_evt[10] = timer8_match_irq;
      src_evt[11] = watch_interval_irq;
      src_evt[12] = watch_main_irq;
      src_evt[13] = key_return_irq;
      src_evt[14] = pin_edge_irq_3;
      src_evt[15] = pin_edge_irq_4;
   end

   assign ack_nmi = core_ack & core_req_ff.nmi;
   assign ack_maskable = core_ack & core_req_ff.irq & ~core_req_ff.nmi;

   // Per source flag: an event wins over any clear in the same cycle.
   genvar gi;
   generate
      for (gi = 0; gi < NUM_SRC; gi++) begin : g_flag
         logic nxt_bit;
         assign ack_clr[gi] = ack_maskable & (core_req_ff.index == 4'(gi));
         always_comb begin
            nxt_bit = request_flags_ff[gi] & ~ack_clr[gi];
            if (flag_wr.wr_en && flag_wr.wr_sel[gi]) begin
               nxt_bit = flag_wr.wr_data[gi];
            end
            if (src_evt[gi]) begin
               nxt_bit = 1'b1;
            end
            nxt_bit = nxt_bit & SRC_VALID[gi];
         end
         assign nxt_flags[gi] = nxt_bit;
      end
   endgenerate

   // The non-maskable flag has the watchdog as its only source.
   always_comb begin
      nxt_nmi = nmi_pending_ff & ~ack_nmi;
      if (watchdog_overflow && watchdog_nmi_mode) begin
         nxt_nmi = 1'b1;
      end
   end

   assign eligible = nxt_flags & ~irq_mask & {16{maskable_enable}};

   fpiv_arbiter u_arbiter (
      .req(eligible),
      .found(win_found),
      .index(win_index)
   );

   // Core request: NMI ignores mask and enable and overrides the maskable winner.
   always_comb begin
      nxt_core_req = '0;
      if (nxt_nmi) begin
         nxt_core_req.nmi = 1'b1;
         nxt_core_req.vector = VEC_NMI;
      end else if (win_found) begin
         nxt_core_req.irq = 1'b1;
         nxt_core_req.index = win_index;
         nxt_core_req.vector = VEC_BASE + {11'h000, win_index, 1'b0};
      end
      nxt_standby = nxt_nmi | (|nxt_flags);
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         request_flags_ff <= FLAGS_RESET;
         nmi_pending_ff <= 1'b0;
         core_req_ff <= '0;
         standby_release_ff <= 1'b0;
      end else begin
         request_flags_ff <= nxt_flags;
         nmi_pending_ff <= nxt_nmi;
         core_req_ff <= nxt_core_req;
         standby_release_ff <= nxt_standby;
      end
   end

   sequence s_maskable_ack;
      core_ack && core_req_ff.irq && !core_req_ff.nmi;
   endsequence

   sequence s_no_retrigger;
      !src_evt[core_req_ff.index] && !flag_wr.wr_en;
   endsequence

   property p_nmi_top;
      @(posedge core_clk) disable iff (sys_rst)
      nmi_pending_ff |-> core_req_ff.nmi && !core_req_ff.irq && core_req_ff.vector == VEC_NMI;
   endproperty
   a_nmi_top: assert property (p_nmi_top) else $error("NMI not offered on top");

   property p_standby;
      @(posedge core_clk) disable iff (sys_rst)
      (nmi_pending_ff || (|request_flags_ff)) |-> standby_release_ff;
   endproperty
   a_standby: assert property (p_standby) else $error("standby release missing");

   property p_nmi_source;
      @(posedge core_clk) disable iff (sys_rst)
      $rose(nmi_pending_ff) |-> $past(watchdog_overflow && watchdog_nmi_mode);
   endproperty
   a_nmi_source: assert property (p_nmi_source) else $error("NMI from bad source");

   property p_wdt_interval;
      @(posedge core_clk) disable iff (sys_rst)
      watchdog_overflow && !watchdog_nmi_mode |=> request_flags_ff[0] && !$rose(nmi_pending_ff);
   endproperty
   a_wdt_interval: assert property (p_wdt_interval) else $error("interval flag not set");

   property p_masked;
      @(posedge core_clk) disable iff (sys_rst)
      core_req_ff.irq |-> (($past(irq_mask) >> core_req_ff.index) & 16'h0001) == 16'h0000
         && $past(maskable_enable);
   endproperty
   a_masked: assert property (p_masked) else $error("masked source offered");

   property p_priority;
      @(posedge core_clk) disable iff (sys_rst)
      core_req_ff.irq |-> (request_flags_ff & ~$past(irq_mask)
         & ((16'h0001 << core_req_ff.index) - 16'h0001)) == 16'h0000;
   endproperty
   a_priority: assert property (p_priority) else $error("lower priority won");

   property p_vector;
      @(posedge core_clk) disable iff (sys_rst)
      core_req_ff.irq |-> core_req_ff.vector == VEC_BASE + {11'h000, core_req_ff.index, 1'b0};
   endproperty
   a_vector: assert property (p_vector) else $error("wrong vector");

   property p_ack_clear;
      @(posedge core_clk) disable iff (sys_rst)
      s_maskable_ack ##0 s_no_retrigger |=> !request_flags_ff[$past(core_req_ff.index)];
   endproperty
   a_ack_clear: assert property (p_ack_clear) else $error("flag kept after ack");

   property p_variant;
      @(posedge core_clk) disable iff (sys_rst)
      (request_flags_ff & ~SRC_VALID) == 16'h0000;
   endproperty
   a_variant: assert property (p_variant) else $error("absent source flagged");
endmodule
